//--- design/tcc_timer.sv
// 16-bit timer/counter slice: counter, two compare units, compare output
// unit with port override, normal and clear-on-match counting.
// Assumes an Avalon-MM master on i_clk and port logic on the same clock.
// Port and acknowledge inputs are same-clock logic and pass no synchronizer.
// Clock enable low freezes every register, the bus handshake included.
// Input capture and PWM waveform shaping are outside this slice.
//
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`default_nettype none

module tcc_timer
    import tcc_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // Avalon-MM slave
    input wire logic [TCC_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Interrupt service acknowledge, one bit per flag
    input wire logic [TCC_FLAG_W-1:0] i_flag_ack,
    // Port logic: general output value and pin direction per channel
    input wire logic [TCC_NCH-1:0] i_port_out,
    input wire logic [TCC_NCH-1:0] i_pin_direction_bit,
    // Flags to the interrupt controller
    output tcc_flags_s o_flags,
    // Compare pins
    output tcc_pin_s [TCC_NCH-1:0] o_pin
);

    // Register state
    // All of it freezes while the clock enable is low
    tcc_ctrl_s ctrl_reg;
    logic [TCC_CW-1:0] count_value_reg;
    logic [TCC_NCH-1:0][TCC_CW-1:0] compare_value_reg;
    logic [TCC_CW-1:0] capture_value_reg;
    tcc_flags_s flags_reg;
    tcc_flags_s flags_next;
    logic [TCC_NCH-1:0] compare_output_state_reg;
    logic block_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    tcc_pin_s [TCC_NCH-1:0] pin_reg;

    // Decoded bus and timer events
    // Strobes last one cycle and are valid only with the clock enable high
    logic wr_fire;
    logic wr_ctrl;
    logic wr_count;
    logic wr_cap;
    logic wr_flags;
    logic wr_force;
    logic tick;
    logic mode_non_pwm;
    logic mode_clears_at_top;
    logic top_from_cap;
    logic [TCC_CW-1:0] top_val;
    logic top_hit;
    logic wrap;
    logic [TCC_NCH-1:0] match;
    logic [TCC_NCH-1:0] force_req;
    logic [TCC_NCH-1:0][1:0] act_sel;
    logic [TCC_CW-1:0] wdata16;

    // Merge the low two byte lanes of a write into a 16-bit register
    // Upper lanes are ignored: the count, compare and capture registers are 16 bits wide
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
        input logic [3:0] be);
        logic [15:0] res;
        res = old;
        if (be[0])
            res[7:0] = data[7:0];
        if (be[1])
            res[15:8] = data[15:8];
        return res;
    endfunction

    // Compare output update for one action code
    // Code 0 keeps the state, so a match under it is harmless
    function automatic logic apply_action(input logic [1:0] act, input logic cur);
        logic res;
        res = cur;
        case (act)
            TCC_ACT_NONE: res = cur;
            TCC_ACT_TOGGLE: res = ~cur;
            TCC_ACT_CLEAR: res = 1'b0;
            TCC_ACT_SET: res = 1'b1;
            default: res = cur;
        endcase
        return res;
    endfunction

    // One wait state: the access completes on the edge after ack_reg rises
    // The wait lets read data come from a register rather than a wide mux.
    // A write lands only at the completing edge, so a master that holds its
    // request through the wait state never writes twice.
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
    assign wr_fire = i_avs_write & ack_reg & i_ce;
    assign wr_ctrl = wr_fire & (i_avs_address == TCC_OFS_CTRL);
    assign wr_count = wr_fire & (i_avs_address == TCC_OFS_COUNT);
    assign wr_cap = wr_fire & (i_avs_address == TCC_OFS_CAPTURE);
    assign wr_flags = wr_fire & (i_avs_address == TCC_OFS_FLAGS);
    assign wr_force = wr_fire & (i_avs_address == TCC_OFS_FORCE);
    assign wdata16 = merge16(count_value_reg, i_avs_writedata, i_avs_byteenable);

    // Bus handshake state; frozen with the clock enable like all other state
    // A low enable stretches the wait only while ack_reg is low; with ack_reg high the access completes and a write is dropped
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            ack_reg <= 1'b0;
        else if (i_ce)
            ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
    end

    // Prescaler producing timer ticks
    // The divider runs on while the timer is stopped, so the first tick after
    // a start comes at an arbitrary phase of the divider
    tcc_prescale u_prescale (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_clk_sel(ctrl_reg.clk_sel),
        .o_tick(tick)
    );

    // Mode decode; only waveform select shapes the counting sequence
    // Modes 14 and 15 only clear at TOP; other PWM modes count freely and
    // hold the output state for a later non-PWM mode
    assign mode_non_pwm = (ctrl_reg.wave == TCC_WGM_NORMAL) |
        (ctrl_reg.wave == TCC_WGM_CTC_CMP) | (ctrl_reg.wave == TCC_WGM_CTC_CAP);
    assign top_from_cap = (ctrl_reg.wave == TCC_WGM_CTC_CAP) |
        (ctrl_reg.wave == TCC_WGM_FPWM_CAP);
    assign mode_clears_at_top = (ctrl_reg.wave == TCC_WGM_CTC_CMP) |
        (ctrl_reg.wave == TCC_WGM_FPWM_CMP) | top_from_cap;

    // TOP is read live from its register; no shadow copy
    // TOP written below the count misses the clear: the count runs to 0xFFFF,
    // wraps to 0x0000 and only then meets TOP
    assign top_val = top_from_cap ? capture_value_reg : compare_value_reg[0];

    // TOP match is lost in the blocked tick, so the count runs on
    assign top_hit = tick & mode_clears_at_top & (count_value_reg == top_val) & ~block_reg;
    // Passing from 0xFFFF to 0x0000 sets overflow in the non-PWM modes, also when a TOP of 0xFFFF
    // clears the count; a counter write in that cycle means no pass
    assign wrap = tick & ~wr_count & (count_value_reg == TCC_MAX);

    // Control register
    // Mode, actions and clock select change together in one write
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            ctrl_reg <= TCC_CTRL_RST;
        else if (i_ce && wr_ctrl)
            ctrl_reg <= tcc_ctrl_s'(i_avs_writedata[TCC_CTRL_W-1:0]);
    end

    // Capture register, software-written only; action select has no path here
    // It serves as TOP in modes 12 and 14 only; nothing in this slice captures
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            capture_value_reg <= TCC_BOTTOM;
        else if (i_ce && wr_cap)
            capture_value_reg <= merge16(capture_value_reg, i_avs_writedata, i_avs_byteenable);
    end

    // Counter: a write wins over a tick and is taken in any mode
    // Software never loses a written value to a tick; the increment of that tick is
    // dropped instead
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            count_value_reg <= TCC_BOTTOM;
        else if (i_ce)
        begin
            if (wr_count)
                count_value_reg <= wdata16;
            else if (top_hit)
                count_value_reg <= TCC_BOTTOM;
            else if (tick)
                count_value_reg <= count_value_reg + 16'h0001;
        end
    end

    // Match blocking lasts until the next tick, however long the timer is stopped
    // A compare value equal to the written count can then be set up without
    // a spurious flag when the timer starts
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            block_reg <= 1'b0;
        else if (i_ce)
        begin
            if (wr_count)
                block_reg <= 1'b1;
            else if (tick)
                block_reg <= 1'b0;
        end
    end

    // Per-channel compare register, comparator, force strobe and output state
    // Channel 0 is unit A, which may also define TOP; channel 1 is unit B
    genvar ch;
    generate
        for (ch = 0; ch < TCC_NCH; ch++)
        begin : g_ch
            // Compare register is unbuffered in the non-PWM modes handled here
            always_ff @(posedge i_clk)
            begin
                if (!i_rst_b)
                    compare_value_reg[ch] <= TCC_BOTTOM;
                else if (i_ce && wr_fire &&
                    i_avs_address == (ch == 0 ? TCC_OFS_CMP_A : TCC_OFS_CMP_B))
                    compare_value_reg[ch] <= merge16(compare_value_reg[ch], i_avs_writedata,
                        i_avs_byteenable);
            end

            // Full 16-bit equality, evaluated on ticks, muted by a counter write
            assign match[ch] = tick & (count_value_reg == compare_value_reg[ch]) & ~block_reg;

            // Force is honoured only outside PWM modes
            // In a PWM mode the strobe is dropped rather than disturb the waveform
            assign force_req[ch] = wr_force & i_avs_writedata[ch] & mode_non_pwm;

            // Action select read live, so a new value acts from the next match
            assign act_sel[ch] = (ch == 0) ? ctrl_reg.act_a : ctrl_reg.act_b;

            // Output state survives mode changes; PWM modes hold it here
            // A match and a force in one cycle apply the action once
            always_ff @(posedge i_clk)
            begin
                if (!i_rst_b)
                    compare_output_state_reg[ch] <= 1'b0;
                else if (i_ce && (force_req[ch] || (match[ch] && mode_non_pwm)))
                    compare_output_state_reg[ch] <= apply_action(act_sel[ch],
                        compare_output_state_reg[ch]);
            end

            // Port override when either action bit is set; direction stays with port
            // One register stage: the pin follows the state a clock later, so set
            // the state before the pin is turned to output
            always_ff @(posedge i_clk)
            begin
                if (!i_rst_b)
                    pin_reg[ch] <= '{out: 1'b0, oe_b: 1'b1};
                else if (i_ce)
                begin
                    pin_reg[ch].out <= (act_sel[ch] != TCC_ACT_NONE) ?
                        compare_output_state_reg[ch] : i_port_out[ch];
                    pin_reg[ch].oe_b <= ~i_pin_direction_bit[ch];
                end
            end
        end
    endgenerate

    // Flag next value: hardware sets win over software and acknowledge clears
    // A set racing a clear leaves the flag set, so no event is lost to a
    // software clear of an older one
    always_comb
    begin
        flags_next = flags_reg;
        if (wr_flags)
            flags_next = flags_next & ~tcc_flags_s'(i_avs_writedata[TCC_FLAG_W-1:0]);
        flags_next = flags_next & ~tcc_flags_s'(i_flag_ack);
        if (wrap && mode_non_pwm)
            flags_next.overflow = 1'b1;
        if (match[0])
            flags_next.match_a = 1'b1;
        if (match[1])
            flags_next.match_b = 1'b1;
        if (top_hit && top_from_cap)
            flags_next.capture = 1'b1;
    end

    // Forced matches never reach the flags or the counter clear
    // The flags hold across a low enable like every other register
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            flags_reg <= TCC_FLAGS_RST;
        else if (i_ce)
            flags_reg <= flags_next;
    end

    // Read data captured in the wait cycle and held for the completing edge
    // Reads have no side effects, so a repeated read disturbs no register
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            rdata_reg <= 32'h00000000;
        else if (i_ce && i_avs_read && !ack_reg)
        begin
            case (i_avs_address)
                TCC_OFS_CTRL: rdata_reg <= {21'h000000, ctrl_reg};
                TCC_OFS_COUNT: rdata_reg <= {16'h0000, count_value_reg};
                TCC_OFS_CMP_A: rdata_reg <= {16'h0000, compare_value_reg[0]};
                TCC_OFS_CMP_B: rdata_reg <= {16'h0000, compare_value_reg[1]};
                TCC_OFS_CAPTURE: rdata_reg <= {16'h0000, capture_value_reg};
                TCC_OFS_FLAGS: rdata_reg <= {28'h0000000, flags_reg};
                TCC_OFS_STATE: rdata_reg <= {30'h00000000, compare_output_state_reg};
                default: rdata_reg <= 32'h00000000; // Force strobe and holes read zero
            endcase
        end
    end

    // Read data, flags and pins all come from registers
    // so nothing glitches while the counter and flags change
    assign o_avs_readdata = rdata_reg;
    assign o_flags = flags_reg;
    assign o_pin = pin_reg;

endmodule

`default_nettype wire

//--- shared/tcc_pkg.sv
// Package for the 16-bit compare timer slice: register map, field layouts,
// mode codes, output actions and prescaler taps.
// Assumes a 32-bit Avalon-MM slave with byte addresses and word-aligned registers.
`default_nettype none

package tcc_pkg;

    // Register byte offsets
    localparam int TCC_ADDR_W = 5;
    localparam logic [4:0] TCC_OFS_CTRL = 5'h00;
    localparam logic [4:0] TCC_OFS_COUNT = 5'h04;
    localparam logic [4:0] TCC_OFS_CMP_A = 5'h08;
    localparam logic [4:0] TCC_OFS_CMP_B = 5'h0C;
    localparam logic [4:0] TCC_OFS_CAPTURE = 5'h10;
    localparam logic [4:0] TCC_OFS_FLAGS = 5'h14;
    localparam logic [4:0] TCC_OFS_FORCE = 5'h18;
    localparam logic [4:0] TCC_OFS_STATE = 5'h1C;

    // Number of compare channels (A and B)
    localparam int TCC_NCH = 2;
    localparam int TCC_CW = 16;
    localparam logic [15:0] TCC_MAX = 16'hFFFF;
    localparam logic [15:0] TCC_BOTTOM = 16'h0000;

    // Waveform select codes handled by this slice
    localparam logic [3:0] TCC_WGM_NORMAL = 4'h0;
    localparam logic [3:0] TCC_WGM_CTC_CMP = 4'h4;
    localparam logic [3:0] TCC_WGM_CTC_CAP = 4'hC;
    localparam logic [3:0] TCC_WGM_FPWM_CAP = 4'hE;
    localparam logic [3:0] TCC_WGM_FPWM_CMP = 4'hF;

    // Output action select codes (non-PWM meaning)
    localparam logic [1:0] TCC_ACT_NONE = 2'h0;
    localparam logic [1:0] TCC_ACT_TOGGLE = 2'h1;
    localparam logic [1:0] TCC_ACT_CLEAR = 2'h2;
    localparam logic [1:0] TCC_ACT_SET = 2'h3;

    // Clock select codes and prescaler tap masks (N = mask + 1)
    localparam logic [2:0] TCC_CS_STOP = 3'h0;
    localparam logic [2:0] TCC_CS_DIV1 = 3'h1;
    localparam logic [2:0] TCC_CS_DIV8 = 3'h2;
    localparam logic [2:0] TCC_CS_DIV64 = 3'h3;
    localparam logic [2:0] TCC_CS_DIV256 = 3'h4;
    localparam logic [2:0] TCC_CS_DIV1024 = 3'h5;
    localparam int TCC_PRE_W = 10;
    localparam logic [9:0] TCC_MASK_DIV1 = 10'h000;
    localparam logic [9:0] TCC_MASK_DIV8 = 10'h007;
    localparam logic [9:0] TCC_MASK_DIV64 = 10'h03F;
    localparam logic [9:0] TCC_MASK_DIV256 = 10'h0FF;
    localparam logic [9:0] TCC_MASK_DIV1024 = 10'h3FF;

    // Control register layout: wave [3:0], act_a [5:4], act_b [7:6], clk_sel [10:8]
    typedef struct packed {
        logic [2:0] clk_sel;
        logic [1:0] act_b;
        logic [1:0] act_a;
        logic [3:0] wave;
    } tcc_ctrl_s;
    localparam int TCC_CTRL_W = 11;
    localparam tcc_ctrl_s TCC_CTRL_RST = '0;

    // Flag register layout: overflow [0], match A [1], match B [2], capture [3]
    typedef struct packed {
        logic capture;
        logic match_b;
        logic match_a;
        logic overflow;
    } tcc_flags_s;
    localparam int TCC_FLAG_W = 4;
    localparam tcc_flags_s TCC_FLAGS_RST = '0;

    // Port pin bundle per compare channel
    typedef struct packed {
        logic out;
        logic oe_b;
    } tcc_pin_s;

endpackage

`default_nettype wire

//--- design/tcc_prescale.sv
// Prescaler for the compare timer: turns the I/O clock into one-cycle timer ticks.
// Assumes the clock select comes from a register on the same clock.
`default_nettype none

module tcc_prescale
    import tcc_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // Control
    input wire logic [2:0] i_clk_sel,
    // Timer tick
    output logic o_tick
);

    logic [TCC_PRE_W-1:0] div_reg;
    logic [TCC_PRE_W-1:0] tap_mask;
    logic tap_valid;

    // Free-running divider shared by all taps, like a common prescaler
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
            div_reg <= '0;
        else if (i_ce)
            div_reg <= div_reg + 10'h001;
    end

    // Tap selection; N of 1, 8, 64, 256 or 1024 sets the tick rate
    always_comb
    begin
        tap_valid = 1'b1;
        case (i_clk_sel)
            TCC_CS_DIV1: tap_mask = TCC_MASK_DIV1;
            TCC_CS_DIV8: tap_mask = TCC_MASK_DIV8;
            TCC_CS_DIV64: tap_mask = TCC_MASK_DIV64;
            TCC_CS_DIV256: tap_mask = TCC_MASK_DIV256;
            TCC_CS_DIV1024: tap_mask = TCC_MASK_DIV1024;
            default:
            begin
                tap_mask = TCC_MASK_DIV1;
                tap_valid = 1'b0; // Stopped; external clock inputs not supported
            end
        endcase
    end

    // Tick when the selected low bits of the divider are all ones
    assign o_tick = i_ce & tap_valid & ((div_reg & tap_mask) == tap_mask);

endmodule

`default_nettype wire

//--- bench/tcc_timer_assertions.sv
// Checker for the compare timer, watching only the top-level ports.
// Assumes one clock domain and a bind from the bench top file.
`default_nettype none

module tcc_timer_assertions
    import tcc_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // Bus
    input wire logic [TCC_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    // Flags and pins
    input wire logic [TCC_FLAG_W-1:0] i_flag_ack,
    input wire logic [TCC_NCH-1:0] i_pin_direction_bit,
    input wire tcc_flags_s o_flags,
    input wire tcc_pin_s [TCC_NCH-1:0] o_pin
);
    logic [3:0] flg;
    logic [3:0] clr_src;
    logic rd_done;

    // Legal causes for a flag to drop: acknowledge or a write-one-clear
    assign flg = o_flags;
    assign rd_done = i_avs_read && !o_avs_waitrequest;
    assign clr_src = i_flag_ack | ((i_avs_write && !o_avs_waitrequest
        && i_avs_address == TCC_OFS_FLAGS) ? i_avs_writedata[3:0] : 4'h0);

    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    property p_one_wait;
        (i_avs_read || i_avs_write) && o_avs_waitrequest && i_ce |=> !o_avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("bus wait state too long");

    property p_idle_ready;
        !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest;
    endproperty
    a_idle_ready: assert property (p_idle_ready) else $error("wait raised while idle");

    property p_flag_fall;
        $past(i_rst_b) |-> (~flg & $past(flg) & ~$past(clr_src)) == 4'h0;
    endproperty
    a_flag_fall: assert property (p_flag_fall)
        else $error("flag dropped without clear");

    property p_freeze;
        !i_ce |=> $stable(flg) && $stable(o_pin);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while disabled");

    property p_dir;
        i_ce |=> o_pin[0].oe_b == !$past(i_pin_direction_bit[0])
            && o_pin[1].oe_b == !$past(i_pin_direction_bit[1]);
    endproperty
    a_dir: assert property (p_dir) else $error("pin enable not from direction");

    property p_rst_vals;
        $rose(i_rst_b) |-> flg == 4'h0 && o_pin[0].oe_b && o_pin[1].oe_b;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("bad values after reset");

    property p_force_rd0;
        rd_done && i_avs_address == TCC_OFS_FORCE |-> o_avs_readdata == 32'h0;
    endproperty
    a_force_rd0: assert property (p_force_rd0) else $error("force reads nonzero");

    property p_hi_zero;
        rd_done && i_avs_address == TCC_OFS_COUNT |-> o_avs_readdata[31:16] == 16'h0;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("count upper bits set");

    c_read: cover property (rd_done);
    c_ovf: cover property ($rose(o_flags.overflow));
    c_dis: cover property (!i_ce ##1 i_ce);
endmodule

`default_nettype wire

//--- bench/tcc_pin_model.sv
// Pin wire model for a compare output pin.
// Assumes no pull resistor, so a released pin drifts every cycle.
`default_nettype none

module tcc_pin_model
    import tcc_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Drive from the block
    input wire tcc_pin_s i_pin,
    // Level on the wire
    output var logic o_level
);
    logic last_reg = 1'b0;

    // Released pin shows the inverse of its last level, so stale data never matches
    always @(posedge i_clk)
        last_reg <= o_level;
    assign o_level = i_pin.oe_b ? ~last_reg : i_pin.out;
endmodule

`default_nettype wire

//--- bench/test_tcc_timer.sv
// Bench for the compare timer: bus tasks, pin model and scored reads.
// Assumes the package, timer, checker and pin model are compiled first.
`default_nettype none

module test_tcc_timer
    import tcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [3:0] MD [3] = '{TCC_WGM_CTC_CMP, TCC_WGM_CTC_CMP, TCC_WGM_CTC_CAP};
    localparam logic [2:0] CS [3] = '{TCC_CS_DIV1, TCC_CS_DIV8, TCC_CS_DIV1};
    localparam int DIVN [3] = '{1, 8, 1};
    localparam int TOPV [3] = '{0, 3, 5};
    localparam logic [31:0] FL [3] = '{32'h7, 32'h7, 32'hF};
    localparam logic [1:0] ACT [4] = '{TCC_ACT_SET, TCC_ACT_CLEAR, TCC_ACT_TOGGLE, TCC_ACT_NONE};
    localparam logic ST [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_ce = 1'b1;
    logic [4:0] adr = 5'h00;
    logic rd_q = 1'b0;
    logic wr_q = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hF;
    logic [3:0] ack = 4'h0;
    logic [1:0] pout = 2'h0;
    logic [1:0] dir = 2'h0;
    logic [31:0] rdata;
    logic wait_q;
    tcc_flags_s flags;
    tcc_pin_s [1:0] pin;
    logic lvl;
    int n_mismatch = 0;
    int checks_done = 0;
    logic [31:0] exp_q [$];
    logic [31:0] seed = 32'hC8E5;

    tcc_timer tcc_timer_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
        .i_avs_address(adr), .i_avs_read(rd_q), .i_avs_write(wr_q),
        .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wait_q), .i_flag_ack(ack), .i_port_out(pout),
        .i_pin_direction_bit(dir), .o_flags(flags), .o_pin(pin));
    tcc_pin_model tcc_pin_model_i (.i_clk(i_clk), .i_pin(pin[0]), .o_level(lvl));

    // Free-running 100 MHz clock
    initial
        forever #5 i_clk = ~i_clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] cw(logic [3:0] m, logic [1:0] a, logic [2:0] c);
        return {21'h0, c, 2'h0, a, m};
    endfunction

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic fail();
        n_mismatch++;
        test_done();
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    // One bus access; waitrequest is sampled mid-cycle so the edge decision is race free
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int k;
        logic busy;
        @(posedge i_clk);
        adr <= a;
        wd <= d;
        be <= {seed[3:2], 2'h3};
        wr_q <= w;
        rd_q <= !w;
        busy = 1'b1;
        for (k = 0; k < 50 && busy; k++)
        begin
            @(negedge i_clk);
            busy = wait_q;
            @(posedge i_clk);
        end
        if (busy)
            fail();
        wr_q <= 1'b0;
        rd_q <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    // Cycles between two changes of compare output A
    task automatic tog(output int n);
        logic v;
        v = pin[0].out;
        for (n = 1; n < 2000; n++)
        begin
            @(posedge i_clk) #1;
            if (pin[0].out !== v)
                return;
        end
        fail();
    endtask

    // Score each read in the cycle its data stands
    always @(negedge i_clk)
        if (rd_q && !wait_q)
            check(rdata, exp_q.size() > 0 ? exp_q.pop_front() : 32'hX);

    // Main sequence
    initial
    begin
        int i;
        int n;
        int k;
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
        rd(TCC_OFS_STATE, 32'h0);
        wr(TCC_OFS_COUNT, 32'h1234);
        rd(TCC_OFS_COUNT, 32'h1234);
        rd(TCC_OFS_FORCE, 32'h0);
        pout <= 2'(rnd());
        // State is set up before the pin is turned to output
        for (i = 0; i < 4; i++)
        begin
            wr(TCC_OFS_CTRL, cw(TCC_WGM_NORMAL, ACT[i], TCC_CS_STOP));
            wr(TCC_OFS_FORCE, 32'h1);
            rd(TCC_OFS_STATE, {31'h0, ST[i]});
        end
        rd(TCC_OFS_FLAGS, 32'h0);
        dir <= 2'h1;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk) check({31'h0, lvl}, {31'h0, pout[0]});
        check({31'h0, pin[1].out}, {31'h0, pout[1]});
        wr(TCC_OFS_CTRL, cw(TCC_WGM_CTC_CMP, TCC_ACT_SET, TCC_CS_STOP));
        rd(TCC_OFS_STATE, 32'h1);
        @(negedge i_clk) check({31'h0, lvl}, 32'h1);
        for (i = 0; i < 3; i++)
        begin
            wr(TCC_OFS_CTRL, cw(MD[i], TCC_ACT_TOGGLE, TCC_CS_STOP));
            wr(TCC_OFS_COUNT, 32'hFFFF); // Blocked first tick wraps to 0, then TOP hits
            wr(TCC_OFS_CMP_A, 32'(TOPV[i]));
            wr(TCC_OFS_CAPTURE, 32'(TOPV[i]));
            wr(TCC_OFS_FLAGS, 32'hF);
            wr(TCC_OFS_CTRL, cw(MD[i], TCC_ACT_TOGGLE, CS[i]));
            tog(n);
            tog(n);
            check(32'(n), 32'(DIVN[i] * (TOPV[i] + 1)));
            tog(n);
            check(32'(n), 32'(DIVN[i] * (TOPV[i] + 1)));
            wr(TCC_OFS_CTRL, cw(MD[i], TCC_ACT_TOGGLE, TCC_CS_STOP));
            rd(TCC_OFS_FLAGS, FL[i]);
        end
        // Normal mode wrap, with a short clock-enable stall on the way
        wr(TCC_OFS_FLAGS, 32'hF);
        wr(TCC_OFS_COUNT, 32'hFFFD);
        wr(TCC_OFS_CTRL, cw(TCC_WGM_NORMAL, TCC_ACT_NONE, TCC_CS_DIV1));
        i_ce <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_ce <= 1'b1;
        for (k = 0; k < 40 && flags.overflow !== 1'b1; k++)
            @(posedge i_clk) #1;
        if (k == 40)
            fail();
        wr(TCC_OFS_CTRL, cw(TCC_WGM_NORMAL, TCC_ACT_NONE, TCC_CS_STOP));
        rd(TCC_OFS_FLAGS, 32'h5);
        ack <= 4'h1;
        @(posedge i_clk);
        ack <= 4'h0;
        rd(TCC_OFS_FLAGS, 32'h4);
        // Count written equal to compare A: first tick must not match
        wr(TCC_OFS_FLAGS, 32'hF);
        wr(TCC_OFS_COUNT, 32'h5);
        wr(TCC_OFS_CTRL, cw(TCC_WGM_NORMAL, TCC_ACT_NONE, TCC_CS_DIV1));
        wr(TCC_OFS_CTRL, cw(TCC_WGM_NORMAL, TCC_ACT_NONE, TCC_CS_STOP));
        rd(TCC_OFS_FLAGS, 32'h0);
        wr(TCC_OFS_COUNT, 32'h4);
        wr(TCC_OFS_CTRL, cw(TCC_WGM_NORMAL, TCC_ACT_NONE, TCC_CS_DIV1));
        wr(TCC_OFS_CTRL, cw(TCC_WGM_NORMAL, TCC_ACT_NONE, TCC_CS_STOP));
        rd(TCC_OFS_FLAGS, 32'h2);
        repeat (2) @(posedge i_clk);
        test_done();
    end
endmodule

bind tcc_timer tcc_timer_assertions tcc_timer_assertions_i (.i_clk(i_clk),
    .i_rst_b(i_rst_b), .i_ce(i_ce), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_flag_ack(i_flag_ack),
    .i_pin_direction_bit(i_pin_direction_bit), .o_flags(o_flags), .o_pin(o_pin));

`default_nettype wire
